// ===== include/aarh_map.svh
`ifndef AARH_MAP_SVH
`define AARH_MAP_SVH
// Alert code types and subtypes
`define AARH_TYPE_PROTO 8'h04
`define AARH_SUB_TOO_MANY 8'h03
`define AARH_SUB_TOO_MUCH 8'h04
`define AARH_TYPE_WARN 8'h06
`define AARH_SUB_PREDICT 8'h02
`define AARH_SUB_HW_FAULT 8'h03
`define AARH_SUB_SLOW 8'h05
`define AARH_SUB_PROTO_CHG 8'h06
`define AARH_TYPE_LER_LO 8'h10
`define AARH_TYPE_LER_HI 8'h19
`define AARH_TYPE_LER_LOCAL 8'h13
`define AARH_TYPE_LER_REMOTE 8'h14
`define AARH_TYPE_MASTER_LO 8'hbc
`define AARH_TYPE_MASTER_HI 8'hbf
`define AARH_TYPE_FAIR 8'hc0
`define AARH_SUB_FAIR_EST 8'h00
`define AARH_SUB_FAIR_DEL 8'h01
`define AARH_INFO_NONE 8'h00
// Reply message layout
`define AARH_REPLY_CODE 8'h07
`define AARH_REPLY_LEN 3'd7
`define AARH_RC_OK 8'h00
`define AARH_RC_INVALID 8'hff
// Resend interval: 500 ms at 25 MHz
`define AARH_RESEND_MS 500
`define AARH_CLK_KHZ 25000
`define AARH_RESEND_CYC (`AARH_RESEND_MS * `AARH_CLK_KHZ)
// Queue depth per port
`define AARH_QDEPTH 4
`endif

// ===== include/aarh_pkg.sv
package aarh_pkg;
    typedef enum logic [1:0] {
        AARH_MODE_KEEP,
        AARH_MODE_WRAP,
        AARH_MODE_PRIV
    } aarh_mode_type;

    typedef enum logic [3:0] {
        AARH_EV_TOO_MANY,
        AARH_EV_TOO_MUCH,
        AARH_EV_PREDICT,
        AARH_EV_HW_FAULT,
        AARH_EV_SLOW,
        AARH_EV_PROTO_CHG,
        AARH_EV_LINK_ERR,
        AARH_EV_FAIR_EST,
        AARH_EV_FAIR_DEL
    } aarh_event_type;

    typedef struct packed {
        logic [7:0] atype;
        logic [7:0] subtype;
        logic [7:0] info;
    } aarh_code_type;

    typedef struct packed {
        aarh_event_type ev;
        logic [7:0] ler_type;
        logic [7:0] arg_a;
        logic [7:0] arg_b;
    } aarh_req_type;

    typedef struct packed {
        aarh_code_type code;
        logic [15:0] tag;
    } aarh_alert_type;
endpackage

// ===== src/aarh_encoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "aarh_map.svh"
module aarh_encoder (
    // Event in
    input wire aarh_pkg::aarh_req_type req,
    // Encoded alert
    output aarh_pkg::aarh_code_type code,
    output aarh_pkg::aarh_mode_type mode,
    output logic legal
);
    // Inclusive byte range test, shared by both code windows
    function automatic logic in_span(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // Map each event to its three-byte code and port mode effect
    always_comb begin
        code = '{atype: `AARH_TYPE_PROTO, subtype: `AARH_SUB_TOO_MANY, info: `AARH_INFO_NONE};
        mode = aarh_pkg::AARH_MODE_KEEP;
        legal = 1'b1;
        unique case (req.ev)
            aarh_pkg::AARH_EV_TOO_MANY: begin
                code.subtype = `AARH_SUB_TOO_MANY;
            end
            aarh_pkg::AARH_EV_TOO_MUCH: begin
                code.subtype = `AARH_SUB_TOO_MUCH;
            end
            aarh_pkg::AARH_EV_PREDICT: begin
                code = '{`AARH_TYPE_WARN, `AARH_SUB_PREDICT, req.arg_a};
            end
            aarh_pkg::AARH_EV_HW_FAULT: begin
                code = '{`AARH_TYPE_WARN, `AARH_SUB_HW_FAULT, `AARH_INFO_NONE};
                mode = aarh_pkg::AARH_MODE_WRAP;
            end
            aarh_pkg::AARH_EV_SLOW: begin
                code = '{`AARH_TYPE_WARN, `AARH_SUB_SLOW, req.arg_a};
            end
            aarh_pkg::AARH_EV_PROTO_CHG: begin
                code = '{`AARH_TYPE_WARN, `AARH_SUB_PROTO_CHG, req.arg_a};
            end
            aarh_pkg::AARH_EV_LINK_ERR: begin
                // Local status only from 13h, remote status from 14h
                code.atype = req.ler_type;
                code.subtype = (req.ler_type >= `AARH_TYPE_LER_LOCAL) ? req.arg_a : 8'h00;
                code.info = (req.ler_type >= `AARH_TYPE_LER_REMOTE) ? req.arg_b : 8'h00;
                mode = aarh_pkg::AARH_MODE_PRIV;
                legal = in_span(req.ler_type, `AARH_TYPE_LER_LO, `AARH_TYPE_LER_HI);
            end
            aarh_pkg::AARH_EV_FAIR_EST: begin
                code = '{`AARH_TYPE_FAIR, `AARH_SUB_FAIR_EST, `AARH_INFO_NONE};
            end
            aarh_pkg::AARH_EV_FAIR_DEL: begin
                code = '{`AARH_TYPE_FAIR, `AARH_SUB_FAIR_DEL, `AARH_INFO_NONE};
            end
            default: begin
                legal = 1'b0;
            end
        endcase
        // Master-only codes never leave this node
        if (in_span(code.atype, `AARH_TYPE_MASTER_LO, `AARH_TYPE_MASTER_HI)) begin
            legal = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== src/aarh_handler.sv
// What this block does
// - Too many outstanding messages encodes as 04h/03h/00h, mode kept.
// - Too much data received encodes as 04h/04h/00h, mode kept.
// - Failure prediction threshold encodes 06h/02h with vendor info byte.
// - Hardware fault encodes 06h/03h/00h and puts the port in Wrap.
// - Slow port encodes 06h/05h with current speed in info byte.
// - Protocol list change encodes 06h/06h with protocol code in info.
// - Link error recovery exits use 10h-19h and set Privileged mode.
// - Codes BCh-BFh are never sent in a node alert.
// - Fairness region changes encode C0h with subtype 00h or 01h.
// - Reply bytes: reply code 07h, return code, tag high, tag low, type, subtype, info.
// - Tag stays allocated and is reused until reconfigured.
// - Replies with mismatching alert code are discarded.
// - Matching tag and code retires the top entry and sends the next.
// - Mismatching replies change neither queue nor port state.
// - Unanswered alert is resent every 500 ms until reply or reset.
// - One alert outstanding per port, the rest wait in a queue.
// - A reply with nothing pending is dropped without effect.
`timescale 1ns/1ps
`default_nettype none
`include "aarh_map.svh"
module aarh_handler #(
    parameter int unsigned RESEND_CYC = `AARH_RESEND_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Node events for this port
    input wire logic ev_valid,
    input wire aarh_pkg::aarh_req_type ev_req,
    output logic ev_ready,
    output logic ev_rejected,
    // Tag and resets from configuration logic
    input wire logic tag_load,
    input wire logic [15:0] tag_value,
    input wire logic total_reset,
    // Reply bytes from the web
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_last,
    // Alert to send
    output logic tx_valid,
    output aarh_pkg::aarh_alert_type tx_alert,
    input wire logic tx_ready,
    // Port state
    output aarh_pkg::aarh_mode_type mode_req,
    output logic mode_req_valid,
    output logic pending,
    output logic reply_ok,
    output logic reply_invalid
);
    // Depth is a power of two so the ring pointers wrap by themselves
    localparam int QD = `AARH_QDEPTH;

    // Encoder result, queue ring, reply buffer and resend timer
    aarh_pkg::aarh_code_type enc_code;
    aarh_pkg::aarh_mode_type enc_mode;
    logic enc_legal;
    aarh_pkg::aarh_code_type queue_q [QD];
    logic [2:0] count_q;
    logic [1:0] head_q;
    logic [1:0] tail_q;
    logic [15:0] tag_q;
    logic outstanding_q;
    logic send_q;
    logic [31:0] timer_q;
    logic [2:0] rx_idx_q;
    logic [7:0] rx_buf_q [7];
    logic rx_done;
    logic reply_match;
    logic push;
    logic pop;
    logic reset_all;

    // Legality is judged on the offered event, before it is queued
    aarh_encoder u_enc (
        .req(ev_req),
        .code(enc_code),
        .mode(enc_mode),
        .legal(enc_legal)
    );

    // Codes compare as whole three-byte fields
    function automatic logic code_eq(aarh_pkg::aarh_code_type a, aarh_pkg::aarh_code_type b);
        return (a.atype == b.atype) && (a.subtype == b.subtype) && (a.info == b.info);
    endfunction

    // Event handshake and status
    assign reset_all = total_reset;
    assign ev_ready = (count_q != 3'(QD)) && !reset_all;
    assign push = ev_valid && ev_ready && enc_legal;
    assign ev_rejected = ev_valid && !enc_legal;
    assign pending = outstanding_q;

    // Reply complete when the seventh byte lands with the frame end
    assign rx_done = rx_valid && rx_last && (rx_idx_q == 3'd6);
    assign reply_match = rx_done && outstanding_q
        && (rx_buf_q[0] == `AARH_REPLY_CODE)
        && ({rx_buf_q[2], rx_buf_q[3]} == tag_q)
        && code_eq({rx_buf_q[4], rx_buf_q[5], rx_byte}, queue_q[head_q]);
    // Return code is not part of the match; it only picks the pulse
    assign pop = reply_match;

    // Gather reply bytes by position
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rx_idx_q <= 3'd0;
            for (int i = 0; i < 7; i++) begin
                rx_buf_q[i] <= 8'h00;
            end
        end else if (reset_all) begin
            // A reply cut by a web reset must not finish on later bytes
            rx_idx_q <= 3'd0;
        end else if (rx_valid) begin
            rx_buf_q[rx_idx_q] <= rx_byte;
            rx_idx_q <= rx_last ? 3'd0 : ((rx_idx_q == 3'd6) ? 3'd6 : rx_idx_q + 3'd1);
        end
    end

    // Queue storage; only the head is ever outstanding
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            head_q <= 2'd0;
            tail_q <= 2'd0;
            count_q <= 3'd0;
            for (int i = 0; i < QD; i++) begin
                queue_q[i] <= '0;
            end
        end else if (reset_all) begin
            head_q <= 2'd0;
            tail_q <= 2'd0;
            count_q <= 3'd0;
        end else begin
            if (push) begin
                queue_q[tail_q] <= enc_code;
                tail_q <= tail_q + 2'd1;
            end
            if (pop) begin
                head_q <= head_q + 2'd1;
            end
            // Push and pop may share a cycle; the count nets them out
            count_q <= count_q + (push ? 3'd1 : 3'd0) - (pop ? 3'd1 : 3'd0);
        end
    end

    // Tag held across replies until configuration replaces it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tag_q <= 16'h0000;
        end else if (tag_load) begin
            // A load mid-alert makes the next resend carry the new tag
            tag_q <= tag_value;
        end
    end

    // Send, wait, resend; next entry starts when the head retires
    // Reset first, then retire, start, hand-off and timer
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            outstanding_q <= 1'b0;
            send_q <= 1'b0;
            timer_q <= 32'd0;
        end else if (reset_all) begin
            outstanding_q <= 1'b0;
            send_q <= 1'b0;
            timer_q <= 32'd0;
        end else if (pop) begin
            outstanding_q <= 1'b0;
            send_q <= 1'b0;
        end else if (!outstanding_q && count_q != 3'd0) begin
            outstanding_q <= 1'b1;
            send_q <= 1'b1;
        end else if (send_q) begin
            if (tx_ready) begin
                send_q <= 1'b0;
                // Timer starts at hand-off, so a slow link cannot shorten the wait
                timer_q <= 32'd0;
            end
        end else if (outstanding_q) begin
            // Repeats forever; only a reply or reset ends it
            if (timer_q >= RESEND_CYC - 1) begin
                send_q <= 1'b1;
                timer_q <= 32'd0;
            end else begin
                timer_q <= timer_q + 32'd1;
            end
        end
    end

    // Offered alert always shows the head entry and the port tag
    assign tx_valid = send_q;
    assign tx_alert = '{code: queue_q[head_q], tag: tag_q};

    // Port mode effect reported when an event is queued
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_req <= aarh_pkg::AARH_MODE_KEEP;
            mode_req_valid <= 1'b0;
        end else begin
            // Only modes that differ from keep raise the valid pulse
            mode_req_valid <= push && (enc_mode != aarh_pkg::AARH_MODE_KEEP);
            mode_req <= push ? enc_mode : aarh_pkg::AARH_MODE_KEEP;
        end
    end

    // Return code of an accepted reply
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reply_ok <= 1'b0;
            reply_invalid <= 1'b0;
        end else begin
            // Other return codes retire the alert but raise neither pulse
            reply_ok <= pop && (rx_buf_q[1] == `AARH_RC_OK);
            reply_invalid <= pop && (rx_buf_q[1] == `AARH_RC_INVALID);
        end
    end
endmodule
`default_nettype wire

// ===== verification/aarh_handler_chk.sv
`timescale 1ns/1ps
`default_nettype none
module aarh_handler_chk #(
    parameter int unsigned RESEND_CYC = 50
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Events
    input wire logic ev_valid,
    input wire aarh_pkg::aarh_req_type ev_req,
    input wire logic ev_ready,
    input wire logic ev_rejected,
    input wire logic total_reset,
    // Web side
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic tx_valid,
    input wire aarh_pkg::aarh_alert_type tx_alert,
    input wire logic tx_ready,
    // Port state
    input wire aarh_pkg::aarh_mode_type mode_req,
    input wire logic mode_req_valid,
    input wire logic pending,
    input wire logic reply_ok,
    input wire logic reply_invalid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic take;
    logic [31:0] wait_q;
    assign take = ev_valid && ev_ready && !ev_rejected;
    // Age of the outstanding alert since its last send
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 32'h0;
        end else if (!pending || (tx_valid && tx_ready)) begin
            wait_q <= 32'h0;
        end else begin
            wait_q <= wait_q + 32'h1;
        end
    end
    property p_wrap;
        take && ev_req.ev == aarh_pkg::AARH_EV_HW_FAULT
            |=> mode_req_valid && mode_req == aarh_pkg::AARH_MODE_WRAP;
    endproperty
    a_wrap: assert property (p_wrap) else $error("fault did not ask for wrap");
    property p_priv;
        take && ev_req.ev == aarh_pkg::AARH_EV_LINK_ERR
            |=> mode_req_valid && mode_req == aarh_pkg::AARH_MODE_PRIV;
    endproperty
    a_priv: assert property (p_priv) else $error("link exit not privileged");
    property p_keep;
        take && !(ev_req.ev inside {aarh_pkg::AARH_EV_HW_FAULT, aarh_pkg::AARH_EV_LINK_ERR})
            |=> !mode_req_valid;
    endproperty
    a_keep: assert property (p_keep) else $error("mode changed for keep event");
    property p_ler;
        ev_valid && ev_req.ev == aarh_pkg::AARH_EV_LINK_ERR
            && !(ev_req.ler_type inside {[8'h10:8'h19]}) |-> ev_rejected;
    endproperty
    a_ler: assert property (p_ler) else $error("bad link type accepted");
    property p_nomaster;
        tx_valid |-> !(tx_alert.code.atype inside {[8'hbc:8'hbf]});
    endproperty
    a_nomaster: assert property (p_nomaster) else $error("master-only code sent");
    property p_hold;
        tx_valid && !tx_ready && !total_reset |=> tx_valid && $stable(tx_alert);
    endproperty
    a_hold: assert property (p_hold) else $error("alert changed before taken");
    property p_drop;
        rx_valid && rx_last && !pending |=> !reply_ok && !reply_invalid;
    endproperty
    a_drop: assert property (p_drop) else $error("reply acted on while idle");
    property p_retire;
        reply_ok || reply_invalid |-> !pending && $past(rx_last);
    endproperty
    a_retire: assert property (p_retire) else $error("reply without retire");
    property p_resend;
        $rose(tx_valid) && $past(pending) |-> wait_q >= RESEND_CYC - 2 && wait_q <= RESEND_CYC;
    endproperty
    a_resend: assert property (p_resend) else $error("resend at wrong time");
    property p_due;
        pending && !total_reset |-> wait_q <= RESEND_CYC + 4;
    endproperty
    a_due: assert property (p_due) else $error("resend overdue");
endmodule
bind aarh_handler aarh_handler_chk #(.RESEND_CYC(RESEND_CYC)) chk_u (
    .mclk(mclk), .rstn(rstn), .ev_valid(ev_valid), .ev_req(ev_req), .ev_ready(ev_ready),
    .ev_rejected(ev_rejected), .total_reset(total_reset), .rx_valid(rx_valid),
    .rx_last(rx_last), .tx_valid(tx_valid), .tx_alert(tx_alert), .tx_ready(tx_ready),
    .mode_req(mode_req), .mode_req_valid(mode_req_valid), .pending(pending),
    .reply_ok(reply_ok), .reply_invalid(reply_invalid)
);
`default_nettype wire

// ===== verification/aarh_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module aarh_master_model (
    // Clock, reset and bench controls
    input wire logic mclk,
    input wire logic rstn,
    input wire logic answer,
    input wire logic [1:0] spoil,
    input wire logic [7:0] rc,
    // Alert in, reply out
    input wire logic tx_valid,
    input wire aarh_pkg::aarh_alert_type tx_alert,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_last
);
    aarh_pkg::aarh_alert_type al;
    logic [7:0] msg [7];
    // Take each alert, reply after a gap; spoil breaks one field on purpose
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_byte = 8'h00;
        forever begin
            @(posedge mclk);
            if (rstn && tx_valid) begin
                tx_ready <= 1'b1;
                @(posedge mclk);
                al = tx_alert;
                tx_ready <= 1'b0;
                msg[0] = (spoil == 2'd3) ? 8'h06 : 8'h07;
                msg[1] = rc;
                msg[2] = al.tag[15:8] ^ {7'h00, spoil == 2'd1};
                msg[3] = al.tag[7:0];
                msg[4] = al.code.atype ^ {7'h00, spoil == 2'd2};
                msg[5] = al.code.subtype;
                msg[6] = al.code.info;
                repeat (3) @(posedge mclk);
                for (int i = 0; i < 7; i++) begin
                    rx_valid <= answer;
                    rx_byte <= msg[i];
                    rx_last <= (i == 6);
                    @(posedge mclk);
                end
                rx_valid <= 1'b0;
                rx_last <= 1'b0;
                rx_byte <= ~msg[6]; // Released line must not look valid
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [3:0] ev;
        logic [7:0] lt;
        logic [7:0] a;
        logic [7:0] b;
        logic [23:0] exp;
    } aarh_row_type;
    logic mclk, rstn, ev_valid, ev_ready, ev_rejected, tag_load, total_reset;
    logic rx_valid, rx_last, tx_valid, tx_ready, mode_req_valid, pending, reply_ok, reply_invalid;
    logic answer, rej_q;
    logic [1:0] spoil;
    logic [7:0] rx_byte, rc;
    logic [15:0] tag_value;
    aarh_pkg::aarh_req_type ev_req;
    aarh_pkg::aarh_alert_type tx_alert;
    aarh_pkg::aarh_mode_type mode_req;
    int checked = 0;
    int err_total = 0;
    int ok_n = 0;
    int n0;
    // Event, link type, args, expected type/subtype/info
    aarh_row_type rows [11] = '{
        '{4'h0, 8'h00, 8'h00, 8'h00, 24'h040300},
        '{4'h1, 8'h00, 8'h00, 8'h00, 24'h040400},
        '{4'h2, 8'h00, 8'h5a, 8'h00, 24'h06025a},
        '{4'h3, 8'h00, 8'h00, 8'h00, 24'h060300},
        '{4'h4, 8'h00, 8'h33, 8'h00, 24'h060533},
        '{4'h5, 8'h00, 8'h0c, 8'h00, 24'h06060c},
        '{4'h6, 8'h10, 8'ha5, 8'h5a, 24'h100000},
        '{4'h6, 8'h13, 8'ha5, 8'h5a, 24'h13a500},
        '{4'h6, 8'h19, 8'ha5, 8'h5a, 24'h19a55a},
        '{4'h7, 8'h00, 8'h00, 8'h00, 24'hc00000},
        '{4'h8, 8'h00, 8'h00, 8'h00, 24'hc00100}
    };
    aarh_handler #(.RESEND_CYC(50)) dut_u (
        .mclk(mclk), .rstn(rstn), .ev_valid(ev_valid), .ev_req(ev_req),
        .ev_ready(ev_ready), .ev_rejected(ev_rejected), .tag_load(tag_load),
        .tag_value(tag_value), .total_reset(total_reset), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_last(rx_last), .tx_valid(tx_valid), .tx_alert(tx_alert),
        .tx_ready(tx_ready), .mode_req(mode_req), .mode_req_valid(mode_req_valid),
        .pending(pending), .reply_ok(reply_ok), .reply_invalid(reply_invalid)
    );
    aarh_master_model model_u (
        .mclk(mclk), .rstn(rstn), .answer(answer), .spoil(spoil), .rc(rc),
        .tx_valid(tx_valid), .tx_alert(tx_alert), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last)
    );
    // Clock and reply pulse count
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        if (reply_ok === 1'b1) ok_n++;
    end
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Bounded wait: 0 alert offered, 1 reply ok, 2 reply invalid
    task automatic waitfor(input int sel, input int lim);
        for (int i = 0; i < lim; i++) begin
            cyc(1);
            if ((sel == 0 ? tx_valid : sel == 1 ? reply_ok : reply_invalid) === 1'b1) return;
        end
        chk("wait", 24'(sel), 24'hffffff);
        close_out();
    endtask
    task automatic send(input logic [3:0] e, input logic [7:0] lt, a, b);
        ev_valid <= 1'b1;
        ev_req <= '{aarh_pkg::aarh_event_type'(e), lt, a, b};
        #2;
        rej_q = ev_rejected;
        cyc(1);
        ev_valid <= 1'b0;
    endtask
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        ev_valid = 1'b0;
        ev_req = '0;
        tag_load = 1'b0;
        tag_value = 16'h0000;
        total_reset = 1'b0;
        answer = 1'b1;
        spoil = 2'h0;
        rc = 8'h00;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        cyc(1);
        chk("idle", {21'h0, tx_valid, pending, ev_ready}, 24'h1);
        tag_load <= 1'b1;
        tag_value <= 16'hbeef;
        cyc(1);
        tag_load <= 1'b0;
        foreach (rows[i]) begin
            send(rows[i].ev, rows[i].lt, rows[i].a, rows[i].b);
            waitfor(0, 20);
            chk("code", tx_alert.code, rows[i].exp);
            chk("tag", {8'h00, tx_alert.tag}, 24'h00beef);
            waitfor(1, 40);
        end
        $display("test table done");
        // Master-only type offered as a link exit must be refused twice over
        send(4'h6, 8'hbd, 8'h00, 8'h00);
        cyc(4);
        chk("reject", {22'h0, rej_q, pending}, 24'h2);
        $display("test refuse done");
        // Broken replies must leave the alert pending until resent
        spoil <= 2'd1;
        rc <= 8'hff;
        send(4'h7, 8'h00, 8'h00, 8'h00);
        for (int s = 2; s < 5; s++) begin
            waitfor(0, 70);
            cyc(20);
            chk("held", {23'h0, pending}, 24'h1);
            spoil <= s[1:0];
        end
        waitfor(2, 70);
        chk("retired", {23'h0, pending}, 24'h0);
        rc <= 8'h00;
        $display("test retry done");
        // Fill queue with master silent, then drain in order
        answer <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            ev_valid <= 1'b1;
            ev_req <= '{aarh_pkg::aarh_event_type'(rows[(k + 9) % 11].ev), 8'h0, 8'h0, 8'h0};
            cyc(1);
        end
        ev_valid <= 1'b0;
        chk("full", {23'h0, ev_ready}, 24'h0);
        // Let the silent frame for the head run out, so the head is resent
        cyc(12);
        answer <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            waitfor(0, 80);
            chk("order", tx_alert.code, rows[(k + 9) % 11].exp);
            waitfor(1, 80);
        end
        $display("test queue done");
        send(4'h0, 8'h00, 8'h00, 8'h00);
        waitfor(0, 20);
        cyc(2);
        n0 = ok_n;
        total_reset <= 1'b1;
        cyc(1);
        total_reset <= 1'b0;
        chk("cleared", {23'h0, pending}, 24'h0);
        cyc(15);
        chk("dropped", 24'(ok_n - n0), 24'h0);
        $display("test abort done");
        close_out();
    end
endmodule
`default_nettype wire
